// ### logic/scrp_pkg.sv
/*
 * Constants, register offsets and field layout of the system clock, reset and
 * power controller. Assumes a single 125 MHz reference clock domain.
 */
package scrp_pkg;
	localparam logic [3:0] A_PLL_CTRL = 4'h0;
	localparam logic [3:0] A_PLL_CFG = 4'h1;
	localparam logic [3:0] A_PLL_STAT = 4'h2;
	localparam logic [3:0] A_PLL_FEED = 4'h3;
	localparam logic [3:0] A_PWR_CTRL = 4'h4;
	localparam logic [3:0] A_PCLK_DIV = 4'h5;
	localparam logic [3:0] A_MEM_MAP = 4'h6;
	localparam logic [3:0] A_EXT_MODE = 4'h7;
	localparam logic [3:0] A_EXT_FLAG = 4'h8;
	localparam logic [3:0] A_EXT_WAKE = 4'h9;
	localparam logic [3:0] A_SYS_STAT = 4'hA;
	localparam logic [3:0] A_EXT_SEL = 4'hB;
	localparam logic [3:0] A_RTC_SRC = 4'hC;
	localparam logic [3:0] A_EXT_POL = 4'hD;
	// pll config fields
	localparam int MSEL_LSB = 0;
	localparam int MSEL_W = 5;
	localparam int PSEL_LSB = 5;
	localparam int PSEL_W = 2;
	// pll control bits
	localparam int PLL_EN_BIT = 0;
	localparam int PLL_CONN_BIT = 1;
	// power control bits
	localparam int PWR_IDLE_BIT = 0;
	localparam int PWR_DOWN_BIT = 1;
	// pll feed sequence
	localparam logic [7:0] FEED_A = 8'hAA;
	localparam logic [7:0] FEED_B = 8'h55;
	// peripheral divider codes
	localparam logic [1:0] PDIV_QUARTER = 2'h0;
	localparam logic [1:0] PDIV_FULL = 2'h1;
	localparam logic [1:0] PDIV_HALF = 2'h2;
	// controlled oscillator limits in MHz, multiplier range
	localparam int CCO_MIN_MHZ = 156;
	localparam int CCO_MAX_MHZ = 320;
	localparam int MULT_MIN = 1;
	localparam int MULT_MAX = 32;
	// timing
	localparam int CLK_MHZ = 125;
	localparam int PLL_LOCK_US = 100;
	localparam int PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
	localparam int WAKE_CYC = 4096;
	localparam int NUM_EXT_PINS = 9;
	localparam int NUM_EXT_IRQ = 4;
	localparam logic [31:0] SECURITY_WORD = 32'h87654321;
	localparam logic [31:0] SECURITY_ADDR = 32'h000001FC;
	localparam logic [31:0] RESET_VECTOR = 32'h00000000;
	typedef enum {ST_RESET, ST_WAKE, ST_RUN, ST_IDLE, ST_PDOWN} scrp_state_t;
endpackage

// ### logic/scrp_top.sv
/*
 * System clock, reset and power controller: pll control, reset sequencing with
 * wake-up timer, brownout, code security, external wake interrupts, vector
 * map, low power modes and peripheral clock enable.
 * Assumes oscillator and flash report status as synchronous levels.
 */
`timescale 1ns/10ps
module scrp_top #(
	parameter int LOCK_CYC = scrp_pkg::PLL_LOCK_CYC,
	parameter int WAKE_CYCLES = scrp_pkg::WAKE_CYC,
	parameter int CCO_IN_MHZ = 12
) (
	input wire logic REF_CLK_I, // reference clock
	input wire logic RST_I, // synchronous reset, active high
	input wire logic [3:0] ADDR_I, // register index
	input wire logic [31:0] WDATA_I, // write data
	input wire logic WR_I, // write strobe
	input wire logic RD_I, // read strobe
	output logic [31:0] RDATA_O, // read data, cycle after read
	input wire logic RESET_PIN_N_I, // external reset, active low
	input wire logic WDT_RESET_I, // watchdog reset request
	input wire logic OSC_OK_I, // oscillator running
	input wire logic FLASH_READY_I, // flash init complete
	input wire logic BOD_WARN_I, // supply below first threshold
	input wire logic BOD_RESET_I, // supply below second threshold
	input wire logic CHECKSUM_OK_I, // boot checksum valid
	input wire logic [31:0] SEC_WORD_I, // word read at security location
	input wire logic CHIP_ERASE_I, // full erase done by isp
	input wire logic [8:0] EXT_PIN_I, // external interrupt pins
	input wire logic CPU_IRQ_I, // any pending processor interrupt
	output logic CHIP_RESET_O, // internal reset, active high
	output logic [31:0] RESET_VECTOR_O, // fetch address after reset
	output logic CPU_CLK_EN_O, // processor clock enable
	output logic CLK_SEL_PLL_O, // processor clock from pll
	output logic PLL_POWER_O, // pll powered
	output logic PLL_LOCK_O, // pll lock status
	output logic [4:0] PLL_MULT_O, // feedback multiplier minus one
	output logic [1:0] PLL_PDIV_O, // output divider code
	output logic OSC_EN_O, // oscillator enable
	output logic PERIPH_CLK_EN_O, // peripheral clock enable pulse
	output logic RTC_CLK_EN_O, // rtc counting allowed
	output logic BOD_IRQ_O, // brownout interrupt
	output logic [3:0] EXT_IRQ_O, // external interrupt requests
	output logic DEBUG_EN_O, // debug access allowed
	output logic VEC_SRAM_O // vectors from sram
);
	import scrp_pkg::*;

	function automatic logic [31:0] cco_mhz(input logic [4:0] m, input logic [1:0] p);
		cco_mhz = 32'(CCO_IN_MHZ) * (32'(m) + 32'h1) * (32'h2 << p);
	endfunction

	////////////////////////////////////////////////////////////////////
	scrp_state_t state_r;
	logic [15:0] wake_cnt_r;
	logic pll_en_r, pll_conn_r, pll_en_act_r, pll_conn_act_r;
	logic [4:0] msel_r, msel_act_r;
	logic [1:0] psel_r, psel_act_r;
	logic feed_a_r;
	logic [15:0] lock_cnt_r;
	logic lock_r;
	logic [1:0] pdiv_r, pcnt_r;
	logic vec_sram_r;
	logic [3:0] ext_mode_r, ext_pol_r, ext_flag_r, ext_wake_r;
	logic [3:0] ext_lvl, ext_prev_r, ext_evt;
	logic [8:0] ext_sel_r;
	logic rtc_ext_r;
	logic debug_en_r, sec_done_r;
	logic wake_req;
	logic cfg_ok;

	// any reset source restarts the wake-up timer
	wire rst_src = RST_I | ~RESET_PIN_N_I | WDT_RESET_I | BOD_RESET_I;

	////////////////////////////////////////////////////////////////////
	// reset and power state sequencing
	always_ff @(posedge REF_CLK_I) begin
		if (rst_src) begin
			state_r <= ST_RESET;
			wake_cnt_r <= 16'h0000;
		end else begin
			case (state_r)
				ST_RESET: begin
					wake_cnt_r <= 16'h0000;
					state_r <= ST_WAKE;
				end
				ST_WAKE: begin
					if (!OSC_OK_I)
						wake_cnt_r <= 16'h0000;
					else if (wake_cnt_r < 16'(WAKE_CYCLES))
						wake_cnt_r <= wake_cnt_r + 16'h0001;
					else if (FLASH_READY_I)
						state_r <= ST_RUN;
				end
				ST_RUN: begin
					if (WR_I && ADDR_I == A_PWR_CTRL && WDATA_I[PWR_DOWN_BIT])
						state_r <= ST_PDOWN;
					else if (WR_I && ADDR_I == A_PWR_CTRL && WDATA_I[PWR_IDLE_BIT])
						state_r <= ST_IDLE;
				end
				ST_IDLE: if (CPU_IRQ_I || |ext_flag_r) state_r <= ST_RUN;
				ST_PDOWN: begin
					if (wake_req) begin
						wake_cnt_r <= 16'h0000;
						state_r <= ST_WAKE;
					end
				end
				default: state_r <= ST_RESET;
			endcase
		end
	end

	// chip reset from a reset source until the first wake after it completes
	logic in_reset_r;
	always_ff @(posedge REF_CLK_I) begin
		if (rst_src)
			in_reset_r <= 1'b1;
		else if (state_r == ST_WAKE && wake_cnt_r >= 16'(WAKE_CYCLES) && FLASH_READY_I)
			in_reset_r <= 1'b0;
	end
	wire sys_rst = rst_src | in_reset_r;

	////////////////////////////////////////////////////////////////////
	// pll control: changes take effect on an aa/55 feed pair
	assign cfg_ok = cco_mhz(msel_r, psel_r) >= 32'(CCO_MIN_MHZ)
		&& cco_mhz(msel_r, psel_r) <= 32'(CCO_MAX_MHZ);

	always_ff @(posedge REF_CLK_I) begin
		if (sys_rst) begin
			pll_en_r <= 1'b0;
			pll_conn_r <= 1'b0;
			msel_r <= 5'h00;
			psel_r <= 2'h0;
		end else if (WR_I && ADDR_I == A_PLL_CTRL) begin
			pll_en_r <= WDATA_I[PLL_EN_BIT];
			pll_conn_r <= WDATA_I[PLL_CONN_BIT];
		end else if (WR_I && ADDR_I == A_PLL_CFG) begin
			msel_r <= WDATA_I[MSEL_LSB +: MSEL_W];
			psel_r <= WDATA_I[PSEL_LSB +: PSEL_W];
		end
	end

	always_ff @(posedge REF_CLK_I) begin
		if (sys_rst)
			feed_a_r <= 1'b0;
		else if (WR_I)
			feed_a_r <= ADDR_I == A_PLL_FEED && WDATA_I[7:0] == FEED_A;
	end
	wire feed_ok = WR_I && ADDR_I == A_PLL_FEED && WDATA_I[7:0] == FEED_B && feed_a_r;

	always_ff @(posedge REF_CLK_I) begin
		if (sys_rst) begin
			pll_en_act_r <= 1'b0;
			pll_conn_act_r <= 1'b0;
			msel_act_r <= 5'h00;
			psel_act_r <= 2'h0;
		end else if (state_r == ST_PDOWN) begin
			pll_en_act_r <= 1'b0;
			pll_conn_act_r <= 1'b0;
		end else if (feed_ok && cfg_ok) begin
			pll_en_act_r <= pll_en_r;
			// connection refused until locked
			pll_conn_act_r <= pll_en_r & pll_conn_r & lock_r;
			msel_act_r <= msel_r;
			psel_act_r <= psel_r;
		end
	end

	// lock modelled as settling count after activation; idle keeps it running
	always_ff @(posedge REF_CLK_I) begin
		if (sys_rst || !pll_en_act_r) begin
			lock_cnt_r <= 16'h0000;
			lock_r <= 1'b0;
		end else if (lock_cnt_r < 16'(LOCK_CYC - 1)) begin
			lock_cnt_r <= lock_cnt_r + 16'h0001;
		end else begin
			lock_r <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// peripheral divider, memory map, rtc source
	always_ff @(posedge REF_CLK_I) begin
		if (sys_rst)
			pdiv_r <= PDIV_QUARTER;
		else if (WR_I && ADDR_I == A_PCLK_DIV)
			pdiv_r <= WDATA_I[1:0];
	end

	always_ff @(posedge REF_CLK_I) begin
		if (sys_rst)
			pcnt_r <= 2'h0;
		else if (state_r == ST_RUN || state_r == ST_IDLE)
			pcnt_r <= pcnt_r + 2'h1;
	end

	always_ff @(posedge REF_CLK_I) begin
		if (sys_rst) begin
			vec_sram_r <= 1'b0;
			rtc_ext_r <= 1'b0;
		end else if (WR_I && ADDR_I == A_MEM_MAP) begin
			vec_sram_r <= WDATA_I[0];
		end else if (WR_I && ADDR_I == A_RTC_SRC) begin
			rtc_ext_r <= WDATA_I[0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// external interrupts: nine pins routed onto four lines
	always_ff @(posedge REF_CLK_I) begin
		if (sys_rst) begin
			ext_mode_r <= 4'h0;
			ext_pol_r <= 4'h0;
			ext_wake_r <= 4'h0;
			ext_sel_r <= 9'h000;
		end else if (WR_I) begin
			if (ADDR_I == A_EXT_MODE) ext_mode_r <= WDATA_I[3:0];
			if (ADDR_I == A_EXT_POL) ext_pol_r <= WDATA_I[3:0];
			if (ADDR_I == A_EXT_WAKE) ext_wake_r <= WDATA_I[3:0];
			if (ADDR_I == A_EXT_SEL) ext_sel_r <= WDATA_I[8:0];
		end
	end

	// pin n feeds line n mod 4 when selected
	always_comb begin
		ext_lvl = ext_pol_r;
		for (int n = 0; n < NUM_EXT_PINS; n++)
			if (ext_sel_r[n] && (EXT_PIN_I[n] ^ ext_pol_r[n % NUM_EXT_IRQ]))
				ext_lvl[n % NUM_EXT_IRQ] = ~ext_pol_r[n % NUM_EXT_IRQ];
		ext_lvl = ext_lvl ^ ext_pol_r;
	end

	always_ff @(posedge REF_CLK_I) begin
		if (sys_rst)
			ext_prev_r <= 4'h0;
		else
			ext_prev_r <= ext_lvl;
	end
	assign ext_evt = ext_mode_r & ext_lvl & ~ext_prev_r | ~ext_mode_r & ext_lvl;

	// set wins over a same-cycle clear; level lines re-set while active
	always_ff @(posedge REF_CLK_I) begin
		if (sys_rst)
			ext_flag_r <= 4'h0;
		else if (WR_I && ADDR_I == A_EXT_FLAG)
			ext_flag_r <= ext_flag_r & ~WDATA_I[3:0] | ext_evt;
		else
			ext_flag_r <= ext_flag_r | ext_evt;
	end

	// wake works on raw levels since clocks are gated in power-down
	assign wake_req = |(ext_lvl & ext_wake_r);

	////////////////////////////////////////////////////////////////////
	// code security: sampled once after reset release
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			debug_en_r <= 1'b1;
			sec_done_r <= 1'b0;
		end else if (CHIP_ERASE_I) begin
			debug_en_r <= 1'b1;
		end else if (!sys_rst && !sec_done_r) begin
			sec_done_r <= 1'b1;
			if (CHECKSUM_OK_I && SEC_WORD_I == SECURITY_WORD)
				debug_en_r <= 1'b0;
		end else if (sys_rst) begin
			sec_done_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// register read port
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			RDATA_O <= 32'h00000000;
		end else if (RD_I) begin
			case (ADDR_I)
				A_PLL_CTRL: RDATA_O <= {30'h0, pll_conn_r, pll_en_r};
				A_PLL_CFG: RDATA_O <= {25'h0, psel_r, msel_r};
				// bit 7 kept spare so the enable, connect and lock bits sit at 8..10
				A_PLL_STAT: RDATA_O <= {21'h0, lock_r, pll_conn_act_r, pll_en_act_r,
					1'b0, psel_act_r, msel_act_r};
				A_PCLK_DIV: RDATA_O <= {30'h0, pdiv_r};
				A_MEM_MAP: RDATA_O <= {31'h0, vec_sram_r};
				A_EXT_MODE: RDATA_O <= {28'h0, ext_mode_r};
				A_EXT_FLAG: RDATA_O <= {28'h0, ext_flag_r};
				A_EXT_WAKE: RDATA_O <= {28'h0, ext_wake_r};
				A_EXT_SEL: RDATA_O <= {23'h0, ext_sel_r};
				A_EXT_POL: RDATA_O <= {28'h0, ext_pol_r};
				A_RTC_SRC: RDATA_O <= {31'h0, rtc_ext_r};
				A_SYS_STAT: RDATA_O <= {29'h0, debug_en_r, BOD_RESET_I, BOD_WARN_I};
				default: RDATA_O <= 32'h00000000;
			endcase
		end else begin
			RDATA_O <= 32'h00000000;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs
	wire running = state_r == ST_RUN;
	assign CHIP_RESET_O = sys_rst;
	assign RESET_VECTOR_O = RESET_VECTOR;
	assign CPU_CLK_EN_O = running && !sys_rst;
	// output divider is at least 2, so the pll clock is 50 percent duty
	assign CLK_SEL_PLL_O = pll_en_act_r & pll_conn_act_r;
	assign PLL_POWER_O = pll_en_act_r;
	assign PLL_LOCK_O = lock_r;
	assign PLL_MULT_O = msel_act_r;
	assign PLL_PDIV_O = psel_act_r;
	assign OSC_EN_O = state_r != ST_PDOWN;
	assign PERIPH_CLK_EN_O = (state_r == ST_RUN || state_r == ST_IDLE) &&
		(pdiv_r == PDIV_FULL || (pdiv_r == PDIV_HALF && !pcnt_r[0]) ||
		(pdiv_r != PDIV_FULL && pdiv_r != PDIV_HALF && pcnt_r == 2'h0));
	assign RTC_CLK_EN_O = state_r != ST_PDOWN || rtc_ext_r;
	assign BOD_IRQ_O = BOD_WARN_I;
	assign EXT_IRQ_O = ext_flag_r;
	assign DEBUG_EN_O = debug_en_r;
	assign VEC_SRAM_O = vec_sram_r;
endmodule

// ### tb/scrp_top_monitor.sv
/* Port-level checks on the clock, reset and power controller.
   Assumes one reference clock and a synchronous active-high reset. */
`timescale 1ns/10ps
module scrp_top_monitor #(
	parameter int LOCK_CYC = 20
) (
	input wire logic REF_CLK_I, // reference clock
	input wire logic RST_I, // sync reset
	input wire logic RD_I, // read strobe
	input wire logic [31:0] RDATA_O, // read data
	input wire logic RESET_PIN_N_I, // pin reset, low
	input wire logic WDT_RESET_I, // watchdog reset
	input wire logic OSC_OK_I, // oscillator ok
	input wire logic FLASH_READY_I, // flash ready
	input wire logic BOD_WARN_I, // supply warning
	input wire logic BOD_RESET_I, // supply too low
	input wire logic CHIP_ERASE_I, // erase done
	input wire logic CHIP_RESET_O, // internal reset
	input wire logic [31:0] RESET_VECTOR_O, // fetch address
	input wire logic CPU_CLK_EN_O, // processor clock enable
	input wire logic CLK_SEL_PLL_O, // pll selected
	input wire logic PLL_POWER_O, // pll powered
	input wire logic PLL_LOCK_O, // pll locked
	input wire logic OSC_EN_O, // oscillator enable
	input wire logic BOD_IRQ_O, // brownout irq
	input wire logic DEBUG_EN_O // debug allowed
);
	// slack over the lock count, absorbs register stages
	localparam int LK = LOCK_CYC + 4;
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);
	sequence s_lock_wait;
		!PLL_LOCK_O [*8] ##[1:LK] (PLL_LOCK_O || !PLL_POWER_O);
	endsequence
	sequence s_sources_gone;
		$past(RESET_PIN_N_I) && !$past(WDT_RESET_I) && !$past(BOD_RESET_I);
	endsequence
	sequence s_release_ready;
		s_sources_gone ##0 ($past(OSC_OK_I) && $past(FLASH_READY_I));
	endsequence
	property p_conn; CLK_SEL_PLL_O |-> PLL_POWER_O && PLL_LOCK_O; endproperty
	a_conn: assert property (p_conn) else $error("pll selected while unlocked");
	property p_bypass; CHIP_RESET_O |=> !PLL_POWER_O && !CLK_SEL_PLL_O; endproperty
	a_bypass: assert property (p_bypass) else $error("pll active in reset");
	property p_lock; $rose(PLL_POWER_O) |-> s_lock_wait; endproperty
	a_lock: assert property (p_lock) else $error("pll lock timing wrong");
	property p_src; !RESET_PIN_N_I || WDT_RESET_I || BOD_RESET_I |-> CHIP_RESET_O; endproperty
	a_src: assert property (p_src) else $error("reset source ignored");
	property p_release; $fell(CHIP_RESET_O) |-> s_release_ready; endproperty
	a_release: assert property (p_release) else $error("reset released early");
	property p_hold; CHIP_RESET_O || !OSC_EN_O |-> !CPU_CLK_EN_O; endproperty
	a_hold: assert property (p_hold) else $error("processor clocked too early");
	property p_vec; RESET_VECTOR_O == 32'h00000000; endproperty
	a_vec: assert property (p_vec) else $error("reset vector not zero");
	property p_wake; $rose(OSC_EN_O) |-> !CPU_CLK_EN_O [*8]; endproperty
	a_wake: assert property (p_wake) else $error("wake timer skipped");
	property p_bod; BOD_IRQ_O == BOD_WARN_I; endproperty
	a_bod: assert property (p_bod) else $error("brownout irq wrong");
	property p_dbg; CHIP_ERASE_I |=> DEBUG_EN_O; endproperty
	a_dbg: assert property (p_dbg) else $error("erase left debug off");
	property p_rdata; !$past(RD_I) |-> RDATA_O == 32'h00000000; endproperty
	a_rdata: assert property (p_rdata) else $error("read data outside slot");
endmodule

// ### tb/scrp_core_model.sv
/* Processor and peripheral stand-in: raises a wake interrupt, counts pclk enables.
   Assumes the bench pulses wake_req_i for one cycle. */
`timescale 1ns/10ps
module scrp_core_model (
	input wire logic clk_i, // reference clock
	input wire logic rst_i, // reset
	input wire logic cpu_clk_en_i, // processor running
	input wire logic periph_clk_en_i, // peripheral enable
	input wire logic wake_req_i, // bench asks for an irq
	output logic cpu_irq_o, // pending interrupt
	output int pclk_cnt_o // peripheral ticks seen
);
	// irq held until the processor runs again, like a real pending source
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cpu_irq_o <= 1'b0;
		end else if (wake_req_i) begin
			cpu_irq_o <= 1'b1;
		end else if (cpu_clk_en_i) begin
			cpu_irq_o <= 1'b0;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pclk_cnt_o <= 0;
		end else if (periph_clk_en_i) begin
			pclk_cnt_o <= pclk_cnt_o + 1;
		end
	end
endmodule

// ### tb/test_system_clock_reset_power_ctrl.sv
/* Self-checking bench for the clock, reset and power controller.
   Assumes shortened lock and wake counts of 20 and 16 cycles. */
`timescale 1ns/10ps
module test_system_clock_reset_power_ctrl;
	import scrp_pkg::*;
	logic REF_CLK_I = 0, RST_I = 1, WR_I = 0, RD_I = 0, RESET_PIN_N_I = 1, WDT_RESET_I = 0;
	logic OSC_OK_I = 1, FLASH_READY_I = 0, BOD_WARN_I = 0, BOD_RESET_I = 0, CHECKSUM_OK_I = 0;
	logic CHIP_ERASE_I = 0, wake_req = 0;
	logic [3:0] ADDR_I = 4'h0;
	logic [31:0] WDATA_I = 32'h0, SEC_WORD_I = 32'h0, RDATA_O, RESET_VECTOR_O, d;
	logic [8:0] EXT_PIN_I = 9'h000;
	logic CPU_IRQ_I, CHIP_RESET_O, CPU_CLK_EN_O, CLK_SEL_PLL_O, PLL_POWER_O, PLL_LOCK_O;
	logic OSC_EN_O, PERIPH_CLK_EN_O, RTC_CLK_EN_O, BOD_IRQ_O, DEBUG_EN_O, VEC_SRAM_O;
	logic [4:0] PLL_MULT_O;
	logic [1:0] PLL_PDIV_O;
	logic [3:0] EXT_IRQ_O;
	int pcnt, c, n, fail_count = 0, tests_run = 0;
	always #4 REF_CLK_I = ~REF_CLK_I;
	scrp_top #(.LOCK_CYC(20), .WAKE_CYCLES(16)) scrp_top_inst (.*);
	scrp_core_model scrp_core_model_inst (.clk_i(REF_CLK_I), .rst_i(RST_I),
		.cpu_clk_en_i(CPU_CLK_EN_O), .periph_clk_en_i(PERIPH_CLK_EN_O),
		.wake_req_i(wake_req), .cpu_irq_o(CPU_IRQ_I), .pclk_cnt_o(pcnt));
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge REF_CLK_I);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge REF_CLK_I);
		ADDR_I <= a;
		WDATA_I <= v;
		WR_I <= 1'b1;
		@(posedge REF_CLK_I);
		WR_I <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		@(posedge REF_CLK_I);
		ADDR_I <= a;
		RD_I <= 1'b1;
		@(posedge REF_CLK_I);
		RD_I <= 1'b0;
		#1 v = RDATA_O;
	endtask
	// both feed words on consecutive cycles; a gap with no writes between them would also be accepted
	task automatic feed();
		@(posedge REF_CLK_I);
		ADDR_I <= A_PLL_FEED;
		WDATA_I <= {24'h0, FEED_A};
		WR_I <= 1'b1;
		@(posedge REF_CLK_I);
		WDATA_I <= {24'h0, FEED_B};
		@(posedge REF_CLK_I);
		WR_I <= 1'b0;
	endtask
	task automatic wait_cpu(output int k);
		k = 0;
		while (CPU_CLK_EN_O !== 1'b1 && k < 300) begin
			tick(1);
			k++;
		end
	endtask
	task automatic chip_rst(input bit dog, output int k);
		@(posedge REF_CLK_I);
		WDT_RESET_I <= dog;
		RESET_PIN_N_I <= dog;
		tick(3);
		WDT_RESET_I <= 1'b0;
		RESET_PIN_N_I <= 1'b1;
		wait_cpu(k);
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		tick(40);
		chk(CHIP_RESET_O, 1'b1);
		FLASH_READY_I <= 1'b1;
		wait_cpu(n);
		chk(CHIP_RESET_O, 1'b0);
		chk(RESET_VECTOR_O, RESET_VECTOR);
		chk({PLL_POWER_O, CLK_SEL_PLL_O}, 2'b00);
		rd(A_PCLK_DIV, d);
		chk(d, {30'h0, PDIV_QUARTER});
		rd(4'hF, d);
		chk(d, 32'h0);
	endtask
	task automatic t_sec();
		CHECKSUM_OK_I <= 1'b1;
		SEC_WORD_I <= SECURITY_WORD;
		chip_rst(1'b0, n);
		chk(n >= 16, 1'b1);
		tick(2);
		chk(DEBUG_EN_O, 1'b0);
		// a reset alone must not unlock debug, even with the word gone
		SEC_WORD_I <= 32'h0;
		chip_rst(1'b1, n);
		chk(n >= 16, 1'b1);
		tick(2);
		chk(DEBUG_EN_O, 1'b0);
		CHIP_ERASE_I <= 1'b1;
		tick(1);
		CHIP_ERASE_I <= 1'b0;
		tick(1);
		chk(DEBUG_EN_O, 1'b1);
		chip_rst(1'b0, n);
		chk(n >= 16, 1'b1);
		tick(2);
		chk(DEBUG_EN_O, 1'b1);
	endtask
	task automatic t_pclk();
		logic [1:0] code [3] = '{PDIV_FULL, PDIV_HALF, PDIV_QUARTER};
		int want [3] = '{16, 8, 4};
		for (int i = 0; i < 3; i++) begin
			wr(A_PCLK_DIV, {30'h0, code[i]});
			tick(2);
			c = pcnt;
			tick(16);
			chk(32'(pcnt - c), 32'(want[i]));
		end
	endtask
	task automatic t_pll();
		logic [6:0] cfg [3] = '{7'h60, 7'h7F, 7'h23};
		logic [6:0] act [3] = '{7'h60, 7'h60, 7'h23};
		for (int i = 0; i < 3; i++) begin
			wr(A_PLL_CFG, {25'h0, cfg[i]});
			feed();
			tick(1);
			chk({PLL_PDIV_O, PLL_MULT_O}, act[i]);
		end
		// software order: enable, wait lock, then connect
		wr(A_PLL_CTRL, 32'h1);
		feed();
		tick(2);
		chk(PLL_LOCK_O, 1'b0);
		n = 0;
		while (PLL_LOCK_O !== 1'b1 && n < 40) begin
			tick(1);
			n++;
		end
		chk(PLL_LOCK_O, 1'b1);
		chk(CLK_SEL_PLL_O, 1'b0);
		wr(A_PLL_CTRL, 32'h3);
		feed();
		tick(1);
		chk(CLK_SEL_PLL_O, 1'b1);
		rd(A_PLL_STAT, d);
		chk(d, 32'h723);
	endtask
	task automatic t_power();
		wr(A_PWR_CTRL, 32'h1);
		tick(2);
		chk(CPU_CLK_EN_O, 1'b0);
		c = pcnt;
		tick(8);
		chk(32'(pcnt - c), 32'd2);
		chk(PLL_POWER_O, 1'b1);
		wake_req <= 1'b1;
		tick(1);
		wake_req <= 1'b0;
		tick(3);
		chk(CPU_CLK_EN_O, 1'b1);
		wr(A_EXT_SEL, 32'h021);
		wr(A_EXT_WAKE, 32'h2);
		for (int s = 0; s < 2; s++) begin
			wr(A_RTC_SRC, s);
			wr(A_PWR_CTRL, 32'h2);
			tick(2);
			chk({OSC_EN_O, CPU_CLK_EN_O, RTC_CLK_EN_O}, {2'b00, s[0]});
			c = pcnt;
			EXT_PIN_I <= 9'h001;
			tick(8);
			chk(32'(pcnt - c), 32'd0);
			chk(OSC_EN_O, 1'b0);
			EXT_PIN_I <= 9'h021;
			wait_cpu(n);
			chk(n >= 16, 1'b1);
			chk({CHIP_RESET_O, EXT_IRQ_O[1]}, 2'b01);
			EXT_PIN_I <= 9'h000;
			wr(A_EXT_FLAG, 32'hF);
			tick(1);
			chk(EXT_IRQ_O, 4'h0);
		end
	endtask
	task automatic t_misc();
		BOD_WARN_I <= 1'b1;
		rd(A_SYS_STAT, d);
		chk({BOD_IRQ_O, d[0]}, 2'b11);
		BOD_WARN_I <= 1'b0;
		wr(A_MEM_MAP, 32'h1);
		tick(1);
		chk(VEC_SRAM_O, 1'b1);
		BOD_RESET_I <= 1'b1;
		tick(2);
		chk({CHIP_RESET_O, CPU_CLK_EN_O}, 2'b10);
		BOD_RESET_I <= 1'b0;
		wait_cpu(n);
		chk(VEC_SRAM_O, 1'b0);
	endtask
	// line 2 edge sensitive on pin 2, line 3 active low on pin 3
	task automatic t_ext();
		wr(A_EXT_SEL, 32'h00C);
		wr(A_EXT_MODE, 32'h4);
		wr(A_EXT_POL, 32'h8);
		tick(1);
		chk(EXT_IRQ_O, 4'h8);
		EXT_PIN_I <= 9'h00C;
		tick(2);
		chk(EXT_IRQ_O, 4'hC);
		// pin 2 still high: an edge line must not set again after clearing
		wr(A_EXT_FLAG, 32'hF);
		tick(1);
		chk(EXT_IRQ_O, 4'h0);
		EXT_PIN_I <= 9'h000;
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#200000;
		fail_count++;
		finish_test();
	end
	initial begin
		repeat (4) @(posedge REF_CLK_I);
		RST_I <= 1'b0;
		t_reset();
		t_sec();
		t_pclk();
		t_pll();
		t_power();
		t_misc();
		t_ext();
		finish_test();
	end
endmodule
bind scrp_top scrp_top_monitor #(.LOCK_CYC(LOCK_CYC)) scrp_top_monitor_inst (.*);
